// File: verilog/dpt_timer.v
/*
 * delay pulse timer: 16-bit up counter cleared by a selectable clear
 * pulse, three compare channels driving three output pins, apb slave.
 * assumes the event divider pulse and the clear pin are synchronous to
 * clk_sys and that software keeps the start-up wait after reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpt_consts.vh"

module dpt_timer (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [15:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  input  wire        ext_clear_pin,
  input  wire        event_divider,
  output wire        out_a,
  output wire        out_b,
  output wire        out_c,
  output wire        capture_irq
);
  // software registers
  reg  [7:0]  timer_control_q;
  reg  [7:0]  input_control_q;
  reg  [7:0]  output_mode_select_q;
  reg  [7:0]  output_enable_level_q;
  reg  [15:0] compare_a_q;
  reg  [15:0] compare_b_q;
  reg  [15:0] compare_c_q;
  reg         prescale_q;
  reg         capture_irq_q;
  // timer state
  reg  [15:0] phase_timer_q;
  reg         clear_lvl_q;
  reg         mode_wr_q;
  reg  [2:0]  en_prev_q;
  reg  [2:0]  match_q;
  reg         clear_edge_q;

  wire        wr_w;
  wire        rd_w;
  wire        mapped_w;
  wire        clear_src_w;
  wire        clear_src_lvl_w;
  wire        count_on_w;
  wire        clear_en_w;
  wire        tick_w;
  wire [2:0]  en_w;
  wire [2:0]  lvl_w;
  wire [2:0]  en_rise_w;
  wire [1:0]  mode_a_w;
  wire [1:0]  mode_b_w;
  wire [1:0]  mode_c_w;
  wire        st_a_w;
  wire        st_b_w;
  wire        st_c_w;

  // address decode shared by write and error paths; the read mux decodes on its own
  function is_mapped;
    input [15:0] a;
    begin
      is_mapped = (a == `DPT_ADDR_TIMER_CONTROL) || (a == `DPT_ADDR_INPUT_CONTROL) ||
                  (a == `DPT_ADDR_OUTPUT_MODE)   || (a == `DPT_ADDR_OUTPUT_ENLVL)  ||
                  (a == `DPT_ADDR_COMPARE_A)     || (a == `DPT_ADDR_COMPARE_B)     ||
                  (a == `DPT_ADDR_COMPARE_C)     || (a == `DPT_ADDR_TIMER_VALUE)   ||
                  (a == `DPT_ADDR_PRESCALE)      || (a == `DPT_ADDR_IRQ_STATUS);
    end
  endfunction

  // channel mode from the mode register, one of four codes per pin
  function [5:0] mode_decode;
    input [5:0] m;
    begin
      case (m)
        `DPT_MODE_D1_RS: mode_decode = {`DPT_CH_DELAY1, `DPT_CH_RS, `DPT_CH_RS};
        `DPT_MODE_D2_RS: mode_decode = {`DPT_CH_DELAY2, `DPT_CH_RS, `DPT_CH_RS};
        `DPT_MODE_TG_RS: mode_decode = {`DPT_CH_TOGGLE, `DPT_CH_RS, `DPT_CH_RS};
        `DPT_MODE_D11: mode_decode = {`DPT_CH_DELAY1, `DPT_CH_DELAY1, `DPT_CH_TOGGLE};
        `DPT_MODE_D21: mode_decode = {`DPT_CH_DELAY2, `DPT_CH_DELAY1, `DPT_CH_TOGGLE};
        `DPT_MODE_D12: mode_decode = {`DPT_CH_DELAY1, `DPT_CH_DELAY2, `DPT_CH_TOGGLE};
        `DPT_MODE_D22: mode_decode = {`DPT_CH_DELAY2, `DPT_CH_DELAY2, `DPT_CH_TOGGLE};
        default: mode_decode = {`DPT_CH_TOGGLE, `DPT_CH_TOGGLE, `DPT_CH_TOGGLE};
      endcase
    end
  endfunction

  // compare hit on the value the counter takes at the coming tick
  function next_hits;
    input [15:0] cnt;
    input [15:0] cmp;
    begin
      next_hits = ((cnt + 16'h0001) == cmp);
    end
  endfunction

  // pin level: disabled pins sit low, level bit one means active high
  function pin_drive;
    input en;
    input st;
    input lvl;
    begin
      pin_drive = en & (st ^ ~lvl);
    end
  endfunction

  // apb slave answers in the access cycle, never waits
  assign pready   = 1'b1;
  assign mapped_w = is_mapped(paddr);
  assign pslverr  = psel && penable && !mapped_w;
  assign wr_w     = psel && penable && pwrite && mapped_w;
  // reads are latched in the setup cycle so the data stands through access
  assign rd_w     = psel && !penable && !pwrite;

  // register writes; byte-wide registers take the whole low byte at once
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      timer_control_q       <= `DPT_RST_BYTE;
      input_control_q       <= `DPT_RST_BYTE;
      output_mode_select_q  <= `DPT_RST_BYTE;
      output_enable_level_q <= `DPT_RST_BYTE;
      compare_a_q           <= `DPT_RST_WORD;
      compare_b_q           <= `DPT_RST_WORD;
      compare_c_q           <= `DPT_RST_WORD;
      prescale_q            <= 1'b0;
    end else if (wr_w) begin
      case (paddr)
        `DPT_ADDR_TIMER_CONTROL: timer_control_q <= pwdata[7:0];
        `DPT_ADDR_INPUT_CONTROL: input_control_q <= pwdata[7:0];
        `DPT_ADDR_OUTPUT_MODE:   output_mode_select_q <= pwdata[7:0];
        `DPT_ADDR_OUTPUT_ENLVL:  output_enable_level_q <= pwdata[7:0];
        `DPT_ADDR_COMPARE_A:     compare_a_q <= pwdata[15:0];
        `DPT_ADDR_COMPARE_B:     compare_b_q <= pwdata[15:0];
        `DPT_ADDR_COMPARE_C:     compare_c_q <= pwdata[15:0];
        `DPT_ADDR_PRESCALE:      prescale_q <= pwdata[`DPT_PS_DIV16];
        default: prescale_q <= prescale_q;
      endcase
    end
  end

  // read mux; write-only control registers read as zero
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (rd_w) begin
      case (paddr)
        `DPT_ADDR_COMPARE_A:   prdata <= {16'h0000, compare_a_q};
        `DPT_ADDR_COMPARE_B:   prdata <= {16'h0000, compare_b_q};
        `DPT_ADDR_COMPARE_C:   prdata <= {16'h0000, compare_c_q};
        `DPT_ADDR_TIMER_VALUE: prdata <= {16'h0000, phase_timer_q};
        `DPT_ADDR_PRESCALE:    prdata <= {31'h00000000, prescale_q};
        `DPT_ADDR_IRQ_STATUS:  prdata <= {31'h00000000, capture_irq_q};
        default:               prdata <= 32'h00000000;
      endcase
    end
  end

  // capture request raised by a source change, cleared by writing one
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      capture_irq_q <= 1'b0;
    end else if (wr_w && paddr == `DPT_ADDR_INPUT_CONTROL &&
                 pwdata[`DPT_IC_CLEAR_SOURCE_SEL] != clear_src_w) begin
      capture_irq_q <= 1'b1;
    end else if (wr_w && paddr == `DPT_ADDR_IRQ_STATUS && pwdata[`DPT_IRQ_CAPTURE]) begin
      capture_irq_q <= 1'b0;
    end
  end
  assign capture_irq = capture_irq_q;

  assign clear_src_w = input_control_q[`DPT_IC_CLEAR_SOURCE_SEL];
  assign count_on_w  = timer_control_q[`DPT_TC_COUNT_CONTROL];
  assign clear_en_w  = timer_control_q[`DPT_TC_CLEAR_ENABLE];
  // selected clear pulse level before it is registered
  assign clear_src_lvl_w = clear_src_w ? event_divider : ext_clear_pin;

  // clear pulse source select and edge detection, both edges count
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      clear_lvl_q  <= 1'b0;
      clear_edge_q <= 1'b0;
    end else begin
      clear_lvl_q  <= clear_src_lvl_w;
      clear_edge_q <= clear_src_lvl_w != clear_lvl_q;
    end
  end

  dpt_prescaler u_prescaler (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .run     (count_on_w),
    .div16   (prescale_q),
    .tick    (tick_w)
  );

  // counter: stop clears, enabled clear edge clears, tick counts
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      phase_timer_q <= `DPT_RST_WORD;
    end else if (!count_on_w) begin
      phase_timer_q <= `DPT_RST_WORD;
    end else if (clear_edge_q && clear_en_w) begin
      phase_timer_q <= `DPT_RST_WORD;
    end else if (tick_w) begin
      phase_timer_q <= phase_timer_q + 16'h0001;
    end
  end

  // registered match strobes, one per compare channel; mode write marker
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      match_q   <= 3'h0;
      mode_wr_q <= 1'b0;
      en_prev_q <= 3'h0;
    end else begin
      // strobes line up with the edge at which the counter reaches the value
      match_q[0] <= tick_w && next_hits(phase_timer_q, compare_a_q);
      match_q[1] <= tick_w && next_hits(phase_timer_q, compare_b_q);
      match_q[2] <= tick_w && next_hits(phase_timer_q, compare_c_q);
      mode_wr_q  <= wr_w && (paddr == `DPT_ADDR_OUTPUT_MODE);
      en_prev_q  <= en_w;
    end
  end

  assign en_w      = output_enable_level_q[`DPT_OEL_EN_LSB+2:`DPT_OEL_EN_LSB];
  assign lvl_w     = output_enable_level_q[`DPT_OEL_LVL_LSB+2:`DPT_OEL_LVL_LSB];
  assign en_rise_w = en_w & ~en_prev_q;
  assign {mode_a_w, mode_b_w, mode_c_w} = mode_decode(output_mode_select_q[5:0]);

  // channel a: toggle or either delay mode, never set/reset
  dpt_channel u_chan_a (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .mode        (mode_a_w),
    .mode_wr     (mode_wr_q),
    .init_lvl    (1'b0),
    .enable_rise (en_rise_w[0]),
    .match       (match_q[0]),
    .match_rst   (1'b0),
    .clear_lvl   (clear_lvl_q),
    .state       (st_a_w)
  );

  // channel b: the set/reset flip-flop, reset by the third compare
  dpt_channel u_chan_b (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .mode        (mode_b_w),
    .mode_wr     (mode_wr_q),
    .init_lvl    (1'b0),
    .enable_rise (en_rise_w[1]),
    .match       (match_q[1]),
    .match_rst   (match_q[2]),
    .clear_lvl   (clear_lvl_q),
    .state       (st_b_w)
  );

  // channel c: toggle only; its state is unused in set/reset mode
  dpt_channel u_chan_c (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .mode        (mode_c_w),
    .mode_wr     (mode_wr_q),
    .init_lvl    (1'b0),
    .enable_rise (en_rise_w[2]),
    .match       (match_q[2]),
    .match_rst   (1'b0),
    .clear_lvl   (clear_lvl_q),
    .state       (st_c_w)
  );

  // pins: state xnor active level, gated by enable
  // c mirrors the inverse of b in rs mode, so with equal active levels the pair never overlaps
  assign out_a = pin_drive(en_w[0], st_a_w, lvl_w[0]);
  assign out_b = pin_drive(en_w[1], st_b_w, lvl_w[1]);
  assign out_c = pin_drive(en_w[2], (mode_c_w == `DPT_CH_RS) ? ~st_b_w : st_c_w,
                           lvl_w[2]);
endmodule // dpt_timer

`default_nettype wire

// File: inc/dpt_consts.vh
/*
 * constants for the delay pulse timer: apb register map, field positions,
 * reset values, mode encodings and prescale figures.
 * assumes a 32-bit apb bus with byte addresses and a 25 MHz system clock.
 */
`ifndef DPT_CONSTS_VH
`define DPT_CONSTS_VH

// apb byte addresses (low 16 bits of paddr)
`define DPT_ADDR_TIMER_CONTROL   16'hFF38
`define DPT_ADDR_INPUT_CONTROL   16'hFF50
`define DPT_ADDR_OUTPUT_MODE     16'hFF54
`define DPT_ADDR_OUTPUT_ENLVL    16'hFF58
`define DPT_ADDR_COMPARE_A       16'hFF60
`define DPT_ADDR_COMPARE_B       16'hFF64
`define DPT_ADDR_COMPARE_C       16'hFF68
`define DPT_ADDR_TIMER_VALUE     16'hFF6C
`define DPT_ADDR_PRESCALE        16'hFF70
`define DPT_ADDR_IRQ_STATUS      16'hFF74

// timer_control fields
`define DPT_TC_CLEAR_ENABLE      0
`define DPT_TC_COUNT_CONTROL     3
// input_control fields
`define DPT_IC_CLEAR_SOURCE_SEL  7
// output_enable_level fields: enable in bits 0..2, level in bits 4..6
`define DPT_OEL_EN_LSB           0
`define DPT_OEL_LVL_LSB          4
// prescale register: bit 0 selects divide by 16
`define DPT_PS_DIV16             0
// irq status register: bit 0 capture request
`define DPT_IRQ_CAPTURE          0

// reset values
`define DPT_RST_BYTE             8'h00
`define DPT_RST_WORD             16'h0000
`define DPT_RST_DIV              4'h0

// prescale terminal counts
`define DPT_DIV8_LAST            4'h7
`define DPT_DIV16_LAST           4'hF

// output mode encodings (low six bits)
`define DPT_MODE_ALL_TOGGLE      6'h00
`define DPT_MODE_D1_RS           6'h16
`define DPT_MODE_D2_RS           6'h17
`define DPT_MODE_TG_RS           6'h14
`define DPT_MODE_D11             6'h0A
`define DPT_MODE_D21             6'h0B
`define DPT_MODE_D12             6'h0E
`define DPT_MODE_D22             6'h0F

// per-channel mode codes
`define DPT_CH_TOGGLE            2'h0
`define DPT_CH_RS                2'h1
`define DPT_CH_DELAY1            2'h2
`define DPT_CH_DELAY2            2'h3

`endif

// File: verilog/dpt_prescaler.v
/*
 * count clock prescaler: divides the system clock by 8 or 16 and gives
 * a one-cycle tick.  assumes it is held cleared while counting is stopped.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpt_consts.vh"

module dpt_prescaler (
  input  wire       clk_sys,
  input  wire       sys_rst,
  input  wire       run,
  input  wire       div16,
  output wire       tick
);
  reg  [3:0] div_q;
  wire [3:0] last_w;

  // terminal count for divide by 8 or 16
  assign last_w = div16 ? `DPT_DIV16_LAST : `DPT_DIV8_LAST;
  assign tick   = run && (div_q == last_w);

  // free count while running, parked at zero while stopped
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= `DPT_RST_DIV;
    end else if (!run || div_q == last_w) begin
      div_q <= `DPT_RST_DIV;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end
endmodule // dpt_prescaler

`default_nettype wire

// File: verilog/dpt_channel.v
/*
 * one output channel flip-flop: toggle, set/reset or delay latch.
 * assumes match strobes are one-cycle pulses and the mode is stable.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dpt_consts.vh"

module dpt_channel (
  input  wire       clk_sys,
  input  wire       sys_rst,
  input  wire [1:0] mode,
  input  wire       mode_wr,
  input  wire       init_lvl,
  input  wire       enable_rise,
  input  wire       match,
  input  wire       match_rst,
  input  wire       clear_lvl,
  output wire       state
);
  reg state_q;
  reg state_d;

  // next state per mode; mode write and enable rise reinitialise
  always @* begin
    state_d = state_q;
    if (mode_wr) begin
      state_d = (mode == `DPT_CH_TOGGLE) ? init_lvl : 1'b0;
    end else if (enable_rise) begin
      state_d = 1'b0;
    end else begin
      case (mode)
        `DPT_CH_TOGGLE: if (match) state_d = ~state_q;
        `DPT_CH_RS: begin
          if (match_rst) state_d = 1'b0;
          else if (match) state_d = 1'b1;
        end
        `DPT_CH_DELAY1: if (match) state_d = clear_lvl;
        `DPT_CH_DELAY2: if (match) state_d = ~clear_lvl;
        default: state_d = state_q;
      endcase
    end
  end

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) state_q <= 1'b0;
    else state_q <= state_d;
  end

  assign state = state_q;
endmodule // dpt_channel

`default_nettype wire

// File: bench/dpt_timer_monitor.sv
/* port checker for dpt_timer: apb answers, pin gating, mode and enable effects.
   assumes it sees only the top ports and is bound from the bench. */
`timescale 1ns/1ps
`default_nettype none
module dpt_timer_monitor (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        ext_clear_pin,
  input wire logic        event_divider,
  input wire logic        out_a,
  input wire logic        out_b,
  input wire logic        out_c,
  input wire logic        capture_irq
);
  logic [7:0] oel_q;
  logic       src_q;
  logic [1:0] run_q;
  wire        wr  = psel & penable & pwrite;
  wire        rds = psel & ~penable & ~pwrite;
  wire        map = paddr inside {16'hFF38, 16'hFF50, 16'hFF54, 16'hFF58, 16'hFF60,
                                  16'hFF64, 16'hFF68, 16'hFF6C, 16'hFF70, 16'hFF74};
  // shadows of the write-only bits, since software cannot read them back
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      oel_q <= 8'h00;
      src_q <= 1'b0;
      run_q <= 2'h0;
    end else begin
      if (wr && paddr == 16'hFF58) oel_q <= pwdata[7:0];
      if (wr && paddr == 16'hFF50) src_q <= pwdata[7];
      run_q <= {run_q[0], (wr && paddr == 16'hFF38) ? pwdata[3] : run_q[0]};
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_addr_map: assert property (pslverr == (psel && penable && !map))
    else $error("pslverr wrong for address");
  a_wo_read_zero: assert property (
    rds && paddr inside {16'hFF38, 16'hFF50, 16'hFF54, 16'hFF58} |=> prdata == 32'h0)
    else $error("write-only register read nonzero");
  a_prdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved without a read");
  a_stop_reads_zero: assert property (
    rds && paddr == 16'hFF6C && run_q == 2'h0 |=> prdata == 32'h0)
    else $error("stopped counter not zero");
  a_off_pin_low: assert property (({out_c, out_b, out_a} & ~oel_q[2:0]) == 3'h0)
    else $error("disabled pin driven");
  a_en_rise_idle: assert property (
    wr && paddr == 16'hFF58 && !oel_q[0] && pwdata[0] |=> ##1 out_a == !$past(pwdata[4], 2))
    else $error("enabled pin not inactive");
  a_level_flip: assert property (
    wr && paddr == 16'hFF58 && oel_q[0] && pwdata[0] && oel_q[4] != pwdata[4]
    |=> out_a != $past(out_a)) else $error("level change not seen on pin");
  a_rs_init: assert property (
    wr && paddr == 16'hFF54 && pwdata[5:0] == 6'h14 && oel_q[2:1] == 2'h3
    && oel_q[6:5] == 2'h3 |-> ##3 (!out_b && out_c)) else $error("set/reset pins not reset");
  a_irq_on_src: assert property (
    wr && paddr == 16'hFF50 && pwdata[7] != src_q |-> ##[1:3] capture_irq)
    else $error("no capture request on source change");
endmodule // dpt_timer_monitor
`default_nettype wire

// File: bench/dpt_clr_model.sv
/* clear pulse source: drives the external clear pin and the event divider level.
   assumes the bench asks for new levels just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module dpt_clr_model (
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  input  wire logic ext_req,
  input  wire logic evt_req,
  output var  logic ext_clear_pin,
  output var  logic event_divider
);
  // levels change only on a rising edge, as the block samples them there
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ext_clear_pin <= 1'b0;
      event_divider <= 1'b0;
    end else begin
      ext_clear_pin <= ext_req;
      event_divider <= evt_req;
    end
  end
endmodule // dpt_clr_model
`default_nettype wire

// File: bench/delay_pulse_timer_outputs_tb_top.sv
/* bench for dpt_timer: apb master tasks, one task per scenario, verdict.
   assumes the clear source model and the port monitor are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module delay_pulse_timer_outputs_tb_top;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic        ext_req = 1'b0;
  logic        evt_req = 1'b0;
  logic [31:0] rv;
  logic        ev;
  wire  [31:0] prdata;
  wire         pready, pslverr, ext_clear_pin, event_divider;
  wire         out_a, out_b, out_c, capture_irq;
  integer      n_mismatch = 0;
  integer      compares = 0;
  localparam logic [35:0] dly_modes = 36'h5D63CE2CA;
  dpt_timer dut (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .ext_clear_pin, .event_divider, .out_a, .out_b, .out_c, .capture_irq);
  dpt_clr_model src (.clk_sys, .sys_rst, .ext_req, .evt_req, .ext_clear_pin, .event_divider);
  // 25 MHz system clock
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic hang;
    n_mismatch++;
    report_and_stop();
  endtask
  // one apb transfer; read data and error are taken at the pready edge
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    integer i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) hang();
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [15:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // let two edges land, then compare the pins as {c, b, a}
  task automatic pc(input logic [2:0] e);
    repeat (2) @(posedge clk_sys);
    chk({29'h0, out_c, out_b, out_a}, {29'h0, e});
  endtask
  task automatic t_regs;
    rd(16'hFF6C);
    chk(rv, 32'h0);
    rd(16'hFF54);
    chk({rv[30:0], ev}, 32'h0);
    rd(16'hFF40);
    chk({rv[30:0], ev}, 32'h1);
    pc(3'h0);
    $display("test regs done");
  endtask
  task automatic t_lvl;
    wr(16'hFF58, 32'h07);
    pc(3'h7);
    wr(16'hFF58, 32'h77);
    pc(3'h0);
    wr(16'hFF58, 32'h57);
    pc(3'h2);
    $display("test levels done");
  endtask
  task automatic t_cnt;
    logic [31:0] v;
    for (int d = 0; d < 2; d++) begin
      wr(16'hFF70, 32'(d));
      wr(16'hFF38, 32'h08);
      rd(16'hFF6C);
      v = rv;
      repeat (78) @(posedge clk_sys);
      rd(16'hFF6C);
      chk(rv - v, 32'h0A >> d);
      wr(16'hFF38, 32'h00);
      rd(16'hFF6C);
      chk(rv, 32'h0);
    end
    $display("test count done");
  endtask
  task automatic t_tog;
    integer i;
    wr(16'hFF58, 32'h77);
    wr(16'hFF60, 32'h03);
    wr(16'hFF64, 32'hFFFF);
    wr(16'hFF68, 32'hFFFF);
    wr(16'hFF54, 32'h00);
    wr(16'hFF38, 32'h08);
    i = 0;
    while (out_a !== 1'b1 && i < 100) begin
      @(posedge clk_sys);
      i++;
    end
    chk({30'h0, i < 100, out_b}, 32'h2);
    wr(16'hFF38, 32'h00);
    wr(16'hFF58, 32'h76);
    pc(3'h0);
    wr(16'hFF58, 32'h77);
    pc(3'h0);
    $display("test toggle done");
  endtask
  // delay and set/reset codes with the clear level low, then high
  task automatic t_dly;
    logic [5:0] mo;
    logic       lv;
    wr(16'hFF60, 32'h02);
    wr(16'hFF64, 32'h02);
    for (int k = 0; k < 12; k++) begin
      mo = dly_modes[6 * (k / 2) +: 6];
      lv = k[0];
      ext_req <= lv;
      wr(16'hFF38, 32'h00);
      wr(16'hFF54, {26'h0, mo});
      pc({mo[4], 2'h0});
      wr(16'hFF38, 32'h08);
      repeat (58) @(posedge clk_sys);
      pc({1'b0, mo[4] | (lv ^ mo[2]), lv ^ mo[0]});
    end
    $display("test delay done");
  endtask
  task automatic t_rs;
    wr(16'hFF70, 32'h0);
    wr(16'hFF38, 32'h00);
    wr(16'hFF68, 32'h04);
    wr(16'hFF54, 32'h14);
    pc(3'h4);
    wr(16'hFF38, 32'h08);
    repeat (24) @(posedge clk_sys);
    pc(3'h3);
    repeat (22) @(posedge clk_sys);
    pc(3'h5);
    $display("test set reset done");
  endtask
  // run the counter, flip one clear source and see whether it cleared
  task automatic run_flip(input logic evt, input logic exp_clr);
    repeat (100) @(posedge clk_sys);
    if (evt) evt_req <= ~evt_req;
    else ext_req <= ~ext_req;
    repeat (6) @(posedge clk_sys);
    rd(16'hFF6C);
    chk({31'h0, rv < 32'h02}, {31'h0, exp_clr});
  endtask
  task automatic t_clr;
    wr(16'hFF50, 32'h00);
    wr(16'hFF38, 32'h09);
    run_flip(1'b0, 1'b1);
    run_flip(1'b1, 1'b0);
    wr(16'hFF38, 32'h08);
    run_flip(1'b0, 1'b0);
    wr(16'hFF50, 32'h80);
    repeat (3) @(posedge clk_sys);
    rd(16'hFF74);
    chk(rv & 32'h1, 32'h1);
    wr(16'hFF74, 32'h01);
    rd(16'hFF74);
    chk(rv & 32'h1, 32'h0);
    wr(16'hFF38, 32'h09);
    run_flip(1'b1, 1'b1);
    run_flip(1'b0, 1'b0);
    $display("test clear done");
  endtask
  // watchdog against a hang anywhere
  initial begin
    repeat (100000) @(posedge clk_sys);
    hang();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (17) @(posedge clk_sys);
    t_regs();
    t_lvl();
    t_cnt();
    t_tog();
    t_dly();
    t_rs();
    t_clr();
    report_and_stop();
  end
endmodule // delay_pulse_timer_outputs_tb_top
bind dpt_timer dpt_timer_monitor mon (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .prdata, .ext_clear_pin, .event_divider, .out_a, .out_b,
  .out_c, .capture_irq);
`default_nettype wire
